// file: rtl/dss_pin_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back.
`timescale 1ns/1ps
interface dss_pin_if;
	logic [6:0] rawLevel;
	logic [6:0] syncLevel;
	modport core (output rawLevel, input syncLevel);
	modport sync (input rawLevel, output syncLevel);
endinterface

// file: rtl/dss_pkg.sv
// Constants and types shared by the digital signal source selector.
package dss_pkg;

	// ----------------------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------------------
	localparam int NUM_CONSUMERS = 8;
	localparam int CODE_WIDTH    = 8;
	localparam int PIN_COUNT     = 7;
	localparam int TEMP_WIDTH    = 8;
	localparam int CONFIG_WIDTH  = 10;
	localparam int MODE_WIDTH    = 4;

	// ----------------------------------------------------------------------------
	// Source codes
	// ----------------------------------------------------------------------------
	localparam logic [7:0] CODE_ON          = 8'h06;
	localparam logic [7:0] CODE_OFF         = 8'h07;
	localparam logic [7:0] CODE_TECH_START  = 8'h0d;
	localparam logic [7:0] CODE_FAULT       = 8'h3d;
	localparam logic [7:0] CODE_HW_ONE      = 8'h46;
	localparam logic [7:0] CODE_HW_TWO      = 8'h47;
	localparam logic [7:0] CODE_HW_THREE    = 8'h48;
	localparam logic [7:0] CODE_HW_FOUR     = 8'h49;
	localparam logic [7:0] CODE_HW_FIVE     = 8'h4a;
	localparam logic [7:0] CODE_HW_SIX      = 8'h4b;
	localparam logic [7:0] CODE_MFI         = 8'h4c;
	localparam logic [7:0] CODE_WARN_MASK   = 8'h9d;
	localparam logic [7:0] CODE_TIMER_ONE   = 8'h9e;
	localparam logic [7:0] CODE_TIMER_TWO   = 8'h9f;
	localparam logic [7:0] CODE_REF_FREQ    = 8'ha3;
	localparam logic [7:0] CODE_SET_FREQ    = 8'ha4;
	localparam logic [7:0] CODE_OVERLOAD    = 8'ha5;
	localparam logic [7:0] CODE_HEAT_SINK   = 8'ha6;
	localparam logic [7:0] CODE_INSIDE      = 8'ha7;
	localparam logic [7:0] CODE_MOTOR_TEMP  = 8'ha8;
	localparam logic [7:0] CODE_GENERAL     = 8'ha9;
	localparam logic [7:0] CODE_OVER_TEMP   = 8'haa;
	localparam logic [7:0] CODE_CMP_ONE     = 8'hab;
	localparam logic [7:0] CODE_CMP_ONE_N   = 8'hac;
	localparam logic [7:0] CODE_CMP_TWO     = 8'had;
	localparam logic [7:0] CODE_CMP_TWO_N   = 8'hae;
	localparam logic [7:0] CODE_DIG_ONE     = 8'haf;
	localparam logic [7:0] CODE_DIG_TWO     = 8'hb0;
	localparam logic [7:0] CODE_DIG_THREE   = 8'hb1;
	localparam logic [7:0] CODE_REF_PERCENT = 8'hb2;
	localparam logic [7:0] CODE_MAINS_FAIL  = 8'hb3;
	localparam logic [7:0] CODE_MOTOR_PROT  = 8'hb4;
	localparam logic [7:0] CODE_LOGIC_ONE   = 8'hdc;
	localparam logic [7:0] CODE_LOGIC_ONE_N = 8'hdd;
	localparam logic [7:0] CODE_LOGIC_TWO   = 8'hde;
	localparam logic [7:0] CODE_LOGIC_TWO_N = 8'hdf;

	// ----------------------------------------------------------------------------
	// Qualifiers and limits
	// ----------------------------------------------------------------------------
	localparam logic [9:0] CONFIG_TECH_A    = 10'h06f;
	localparam logic [9:0] CONFIG_TECH_B    = 10'h19b;
	localparam logic [3:0] MFI_MODE_DIGITAL = 4'h3;
	localparam logic [8:0] HEAT_SINK_LIMIT  = 9'h050;
	localparam logic [8:0] INSIDE_LIMIT     = 9'h041;

	// ----------------------------------------------------------------------------
	// Pin positions and reset values
	// ----------------------------------------------------------------------------
	localparam int PIN_HW_ONE = 0;
	localparam int PIN_MFI    = 6;
	localparam logic [PIN_COUNT-1:0]     PIN_RESET = 7'h00;
	localparam logic [NUM_CONSUMERS-1:0] OUT_RESET = 8'h00;

	typedef struct packed {
		logic [PIN_COUNT-1:0] stageOne;
		logic [PIN_COUNT-1:0] stageTwo;
	} dss_sync_state_type;

	typedef struct packed {
		logic [NUM_CONSUMERS-1:0] consumerLevel;
		logic                     controllerRelease;
	} dss_state_type;

endpackage

// file: rtl/dss_selector.sv
// Top of the digital signal source selector.
`timescale 1ns/1ps
module dss_selector
	import dss_pkg::*;
(
	input  wire logic                                   core_clk,
	input  wire logic                                   sys_rst,
	input  wire logic [NUM_CONSUMERS-1:0][CODE_WIDTH-1:0] sourceCode,
	input  wire logic [5:0]                             hwInputPin,
	input  wire logic                                   multifunctionInputPin,
	input  wire logic [MODE_WIDTH-1:0]                  multifunctionInputMode,
	input  wire logic                                   remoteActive,
	input  wire logic [5:0]                             remoteBits,
	input  wire logic [CONFIG_WIDTH-1:0]                driveConfig,
	input  wire logic                                   techStartCmd,
	input  wire logic                                   faultDetected,
	input  wire logic                                   warningMaskHit,
	input  wire logic                                   timerOneOut,
	input  wire logic                                   timerTwoOut,
	input  wire logic                                   refFreqReached,
	input  wire logic                                   setFreqAtMostActual,
	input  wire logic                                   overloadWarning,
	input  wire logic [TEMP_WIDTH-1:0]                  heatSinkTemp,
	input  wire logic [TEMP_WIDTH-1:0]                  heatSinkOffset,
	input  wire logic [TEMP_WIDTH-1:0]                  insideTemp,
	input  wire logic [TEMP_WIDTH-1:0]                  insideOffset,
	input  wire logic                                   motorTemperatureWarning,
	input  wire logic                                   motorTemperatureExceeded,
	input  wire logic                                   generalWarning,
	input  wire logic                                   comparatorOne,
	input  wire logic                                   comparatorTwo,
	input  wire logic [2:0]                             digitalOutputSignal,
	input  wire logic                                   refPercentReached,
	input  wire logic                                   mainsFailure,
	input  wire logic                                   voltageCtrlActive,
	input  wire logic                                   motorProtectionTrip,
	input  wire logic                                   logicModuleOne,
	input  wire logic                                   logicModuleTwo,
	output      logic [NUM_CONSUMERS-1:0]               consumerLevel,
	output      logic                                   controllerRelease
);

	// ----------------------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------------------
	dss_pin_if pinBus ();

	assign pinBus.rawLevel = {multifunctionInputPin, hwInputPin};

	dss_sync syncUnit (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pins     (pinBus)
	);

	logic [PIN_COUNT-1:0] pinLevel;

	assign pinLevel = pinBus.syncLevel;

	// ----------------------------------------------------------------------------
	// Derived sources
	// ----------------------------------------------------------------------------
	logic [5:0] inputSource;
	logic       techStart;
	logic       heatSinkWarning;
	logic       insideWarning;
	logic       overTemperature;
	logic       mainsRegulating;

	// Input one is never remote: it must release the controller from the pin.
	assign inputSource[0] = pinLevel[PIN_HW_ONE];

	genvar gi;
	generate
		for (gi = 1; gi < 6; gi++) begin : gRemote
			assign inputSource[gi] = remoteActive ? remoteBits[gi-1] : pinLevel[gi];
		end
	endgenerate

	logic mfiLevel;

	// In analog modes the input reads low so a stray code cannot misfire.
	assign mfiLevel = remoteActive ? remoteBits[5] : pinLevel[PIN_MFI];

	assign techStart = techStartCmd
		&& ((driveConfig == CONFIG_TECH_A) || (driveConfig == CONFIG_TECH_B));

	// Adding the offset avoids an underflow when it exceeds the base limit.
	assign heatSinkWarning = ({1'b0, heatSinkTemp} + {1'b0, heatSinkOffset})
		>= HEAT_SINK_LIMIT;
	assign insideWarning   = ({1'b0, insideTemp} + {1'b0, insideOffset})
		>= INSIDE_LIMIT;
	assign overTemperature = heatSinkWarning || insideWarning
		|| motorTemperatureExceeded;
	assign mainsRegulating = mainsFailure && voltageCtrlActive;

	// ----------------------------------------------------------------------------
	// Source decode
	// ----------------------------------------------------------------------------
	function automatic logic selectSource(input logic [CODE_WIDTH-1:0] code);
		logic level;
		level = 1'b0;
		case (code)
			CODE_ON: begin
				level = 1'b1;
			end
			CODE_OFF: begin
				level = 1'b0;
			end
			CODE_TECH_START: begin
				level = techStart;
			end
			CODE_FAULT: begin
				level = faultDetected;
			end
			CODE_HW_ONE: begin
				level = inputSource[0];
			end
			CODE_HW_TWO: begin
				level = inputSource[1];
			end
			CODE_HW_THREE: begin
				level = inputSource[2];
			end
			CODE_HW_FOUR: begin
				level = inputSource[3];
			end
			CODE_HW_FIVE: begin
				level = inputSource[4];
			end
			CODE_HW_SIX: begin
				level = inputSource[5];
			end
			CODE_MFI: begin
				level = (multifunctionInputMode == MFI_MODE_DIGITAL) && mfiLevel;
			end
			CODE_WARN_MASK: begin
				level = warningMaskHit;
			end
			CODE_TIMER_ONE: begin
				level = timerOneOut;
			end
			CODE_TIMER_TWO: begin
				level = timerTwoOut;
			end
			CODE_REF_FREQ: begin
				level = refFreqReached;
			end
			CODE_SET_FREQ: begin
				level = setFreqAtMostActual;
			end
			CODE_OVERLOAD: begin
				level = overloadWarning;
			end
			CODE_HEAT_SINK: begin
				level = heatSinkWarning;
			end
			CODE_INSIDE: begin
				level = insideWarning;
			end
			CODE_MOTOR_TEMP: begin
				level = motorTemperatureWarning;
			end
			CODE_GENERAL: begin
				level = generalWarning;
			end
			CODE_OVER_TEMP: begin
				level = overTemperature;
			end
			CODE_CMP_ONE: begin
				level = comparatorOne;
			end
			CODE_CMP_ONE_N: begin
				level = !comparatorOne;
			end
			CODE_CMP_TWO: begin
				level = comparatorTwo;
			end
			CODE_CMP_TWO_N: begin
				level = !comparatorTwo;
			end
			CODE_DIG_ONE: begin
				level = digitalOutputSignal[0];
			end
			CODE_DIG_TWO: begin
				level = digitalOutputSignal[1];
			end
			CODE_DIG_THREE: begin
				level = digitalOutputSignal[2];
			end
			CODE_REF_PERCENT: begin
				level = refPercentReached;
			end
			CODE_MAINS_FAIL: begin
				level = mainsRegulating;
			end
			CODE_MOTOR_PROT: begin
				level = motorProtectionTrip;
			end
			CODE_LOGIC_ONE: begin
				level = logicModuleOne;
			end
			CODE_LOGIC_ONE_N: begin
				level = !logicModuleOne;
			end
			CODE_LOGIC_TWO: begin
				level = logicModuleTwo;
			end
			CODE_LOGIC_TWO_N: begin
				level = !logicModuleTwo;
			end
			default: begin
				level = 1'b0;
			end
		endcase
		return level;
	endfunction

	// ----------------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------------
	dss_state_type state;
	dss_state_type next_state;

	// Every consumer is refreshed each cycle, so a code change takes effect next edge.
	always_comb begin
		next_state = state;
		for (int i = 0; i < NUM_CONSUMERS; i++) begin
			next_state.consumerLevel[i] = selectSource(sourceCode[i]);
		end
		next_state.controllerRelease = pinLevel[PIN_HW_ONE];
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '{consumerLevel: OUT_RESET, controllerRelease: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign consumerLevel     = state.consumerLevel;
	assign controllerRelease = state.controllerRelease;

endmodule

// file: rtl/dss_sync.sv
// Two flip-flop synchroniser for the asynchronous input pins.
`timescale 1ns/1ps
module dss_sync
	import dss_pkg::*;
(
	input wire logic core_clk,
	input wire logic sys_rst,
	dss_pin_if.sync  pins
);

	dss_sync_state_type state;
	dss_sync_state_type next_state;

	// ----------------------------------------------------------------------------
	// Stages
	// ----------------------------------------------------------------------------
	// The first stage feeds only the second; nothing else may look at it.
	always_comb begin
		next_state          = state;
		next_state.stageOne = pins.rawLevel;
		next_state.stageTwo = state.stageOne;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '{stageOne: PIN_RESET, stageTwo: PIN_RESET};
		end else begin
			state <= next_state;
		end
	end

	assign pins.syncLevel = state.stageTwo;

endmodule

// file: sim/dss_selector_chk.sv
// Concurrent checks on the ports of the source selector.
`timescale 1ns/1ps
module dss_selector_chk
	import dss_pkg::*;
(
	input wire logic            core_clk,
	input wire logic            sys_rst,
	input wire logic [7:0][7:0] sourceCode,
	input wire logic [5:0]      hwInputPin,
	input wire logic [3:0]      multifunctionInputMode,
	input wire logic            remoteActive,
	input wire logic [5:0]      remoteBits,
	input wire logic [9:0]      driveConfig,
	input wire logic            techStartCmd,
	input wire logic [7:0]      heatSinkTemp,
	input wire logic [7:0]      heatSinkOffset,
	input wire logic            comparatorOne,
	input wire logic [7:0]      consumerLevel,
	input wire logic            controllerRelease
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Pin paths need several clean edges after reset before history means anything.
	logic [2:0] upCnt;
	logic [8:0] heatSum;
	logic [7:0] code;
	assign heatSum = {1'b0, heatSinkTemp} + {1'b0, heatSinkOffset};
	assign code = sourceCode[0];
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			upCnt <= 3'h0;
		else if (upCnt != 3'h7)
			upCnt <= upCnt + 3'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	// The edge that sees reset fall still reloads reset values, so checks wait one edge more.
	default disable iff (sys_rst || upCnt == 3'h0);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_code_on: assert property (code == CODE_ON |=> consumerLevel[0])
		else $error("constant high code gave low");
	a_code_off: assert property (code == CODE_OFF |=> !consumerLevel[0])
		else $error("constant low code gave high");
	a_release_pin: assert property (upCnt > 3'h3 |->
		controllerRelease == $past(hwInputPin[0], 3)) else $error("release path wrong");
	a_remote_bit: assert property (code == CODE_HW_TWO && remoteActive |=>
		consumerLevel[0] == $past(remoteBits[0])) else $error("remote bit not used");
	a_mfi_mode: assert property (code == CODE_MFI &&
		multifunctionInputMode != MFI_MODE_DIGITAL |=> !consumerLevel[0])
		else $error("multifunction passed in wrong mode");
	a_tech_gate: assert property (code == CODE_TECH_START |=> consumerLevel[0] ==
		$past(techStartCmd && (driveConfig == CONFIG_TECH_A || driveConfig == CONFIG_TECH_B)))
		else $error("start gate wrong");
	a_heat_limit: assert property (code == CODE_HEAT_SINK |=>
		consumerLevel[0] == $past(heatSum >= HEAT_SINK_LIMIT)) else $error("heat limit wrong");
	a_cmp_inverse: assert property (code == CODE_CMP_ONE_N |=>
		consumerLevel[0] != $past(comparatorOne)) else $error("inverse wrong");
	a_unknown_low: assert property (code == 8'h00 |=> !consumerLevel[0])
		else $error("unknown code gave high");
	c_remote: cover property (code == CODE_HW_TWO && remoteActive);
	c_heat: cover property (code == CODE_HEAT_SINK && heatSum == HEAT_SINK_LIMIT);
	c_tech: cover property (code == CODE_TECH_START && driveConfig == CONFIG_TECH_B);
endmodule

// file: sim/dss_selector_tb.sv
// Self-checking bench for the digital signal source selector.
`timescale 1ns/1ps
module dss_selector_tb import dss_pkg::*;;
	logic            core_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic [7:0][7:0] sourceCode = 64'h0;
	logic [6:0]      pinWant = 7'h00;
	logic [3:0]      multifunctionInputMode = 4'h3;
	logic            remoteActive = 1'b0;
	logic [5:0]      remoteBits = 6'h00;
	logic [9:0]      driveConfig = 10'h000;
	logic [21:0]     fl = 22'h000000;
	logic [7:0]      heatSinkTemp = 8'h00;
	logic [7:0]      heatSinkOffset = 8'h00;
	logic [7:0]      insideTemp = 8'h00;
	logic [7:0]      insideOffset = 8'h00;
	logic [5:0]      hwInputPin;
	logic            multifunctionInputPin;
	logic [7:0]      consumerLevel;
	logic            controllerRelease;
	int              fails = 0;
	int              cmpCount = 0;
	int              cyc = 0;
	localparam logic [7:0] FLAG_CODE [23] = '{CODE_FAULT, CODE_WARN_MASK, CODE_TIMER_ONE,
		CODE_TIMER_TWO, CODE_REF_FREQ, CODE_SET_FREQ, CODE_OVERLOAD, CODE_GENERAL,
		CODE_OVER_TEMP, CODE_REF_PERCENT, CODE_CMP_ONE, CODE_CMP_ONE_N, CODE_CMP_TWO,
		CODE_CMP_TWO_N, CODE_DIG_ONE, CODE_DIG_TWO, CODE_DIG_THREE, CODE_LOGIC_ONE,
		CODE_LOGIC_ONE_N, CODE_LOGIC_TWO, CODE_LOGIC_TWO_N, CODE_MOTOR_TEMP, CODE_MOTOR_PROT};
	localparam int FLAG_BIT [23] = '{1, 2, 3, 4, 5, 6, 7, 10, 9, 16, 11, 11, 12, 12, 13, 14,
		15, 20, 20, 21, 21, 8, 19};
	always #2.5 core_clk = ~core_clk;
	dss_terminals term_u (.core_clk, .pinWant, .hwInputPin, .multifunctionInputPin);
	dss_selector dut_u (.core_clk, .sys_rst, .sourceCode, .hwInputPin, .multifunctionInputPin,
		.multifunctionInputMode, .remoteActive, .remoteBits, .driveConfig,
		.techStartCmd(fl[0]), .faultDetected(fl[1]), .warningMaskHit(fl[2]),
		.timerOneOut(fl[3]), .timerTwoOut(fl[4]), .refFreqReached(fl[5]),
		.setFreqAtMostActual(fl[6]), .overloadWarning(fl[7]), .heatSinkTemp, .heatSinkOffset,
		.insideTemp, .insideOffset, .motorTemperatureWarning(fl[8]),
		.motorTemperatureExceeded(fl[9]), .generalWarning(fl[10]), .comparatorOne(fl[11]),
		.comparatorTwo(fl[12]), .digitalOutputSignal(fl[15:13]), .refPercentReached(fl[16]),
		.mainsFailure(fl[17]), .voltageCtrlActive(fl[18]), .motorProtectionTrip(fl[19]),
		.logicModuleOne(fl[20]), .logicModuleTwo(fl[21]), .consumerLevel, .controllerRelease);
	task chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
		cmpCount++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task set0(input logic [7:0] c);
		@(posedge core_clk);
		sourceCode[0] <= c;
	endtask
	task t_const();
		set0(CODE_ON);
		sourceCode[7] <= CODE_OFF;
		fl <= 22'h3fffff;
		wt(1);
		chk("on", consumerLevel[0], 1'b1);
		chk("off7", consumerLevel[7], 1'b0);
		set0(CODE_OFF);
		sourceCode[7] <= CODE_ON;
		wt(1);
		chk("off", consumerLevel[0], 1'b0);
		chk("on7", consumerLevel[7], 1'b1);
		set0(8'h00);
		wt(1);
		chk("unknown", consumerLevel[0], 1'b0);
		set0(8'hff);
		wt(1);
		chk("unknown", consumerLevel[0], 1'b0);
		@(posedge core_clk);
		sourceCode <= {CODE_ON, CODE_OFF, CODE_OFF, CODE_ON, CODE_ON, CODE_OFF, CODE_ON, 8'h00};
		wt(1);
		chk("lanes", {2'b00, consumerLevel}, 10'h09a);
	endtask
	task t_flags();
		logic e;
		for (int i = 0; i < 23; i++) begin
			for (int v = 0; v < 2; v++) begin
				set0(FLAG_CODE[i]);
				fl <= 22'(v) << FLAG_BIT[i];
				wt(1);
				e = 1'(v) ^ (FLAG_CODE[i] inside {CODE_CMP_ONE_N, CODE_CMP_TWO_N,
					CODE_LOGIC_ONE_N, CODE_LOGIC_TWO_N});
				if (i < 6) chk("flag", consumerLevel[0], e);
				else if (i < 10) chk("flag", consumerLevel[0], e);
				else chk("flag", consumerLevel[0], e);
			end
		end
	endtask
	task t_pins();
		for (int i = 0; i < 6; i++) begin
			set0(CODE_HW_ONE + 8'(i));
			remoteActive <= 1'b0;
			pinWant <= 7'h01 << i;
			wt(3);
			chk("pin", consumerLevel[0], 1'b1);
			chk("release", controllerRelease, 1'(i == 0));
			@(posedge core_clk);
			pinWant <= 7'h00;
			remoteActive <= 1'b1;
			remoteBits <= (i == 0) ? 6'h3f : 6'h01 << (i - 1);
			wt(3);
			chk("remote", consumerLevel[0], 1'(i != 0));
		end
	endtask
	task t_mfi();
		for (int k = 0; k < 4; k++) begin
			set0(CODE_MFI);
			multifunctionInputMode <= k[0] ? 4'h2 : MFI_MODE_DIGITAL;
			remoteActive <= k[1];
			pinWant <= {!k[1], 6'h00};
			remoteBits <= {k[1], 5'h00};
			wt(3);
			chk("mfi", consumerLevel[0], !k[0]);
		end
	endtask
	task t_tech();
		for (int k = 0; k < 4; k++) begin
			set0(CODE_TECH_START);
			fl <= 22'(k != 3);
			driveConfig <= (k == 2) ? CONFIG_TECH_B - 10'h001 :
				((k == 1) ? CONFIG_TECH_B : CONFIG_TECH_A);
			wt(1);
			chk("tech", consumerLevel[0], 1'(k < 2));
		end
	endtask
	task t_mains();
		for (int k = 0; k < 4; k++) begin
			set0(CODE_MAINS_FAIL);
			fl <= 22'(k) << 17;
			wt(1);
			chk("mains", consumerLevel[0], 1'(k == 3));
		end
	endtask
	task tmp(input logic [7:0] c, hT, hO, iT, iO, input logic e);
		set0(c);
		fl <= 22'h000000;
		heatSinkTemp <= hT;
		heatSinkOffset <= hO;
		insideTemp <= iT;
		insideOffset <= iO;
		wt(1);
		chk("temp", consumerLevel[0], e);
	endtask
	task t_temp();
		tmp(CODE_HEAT_SINK, 8'h46, 8'h0a, 8'h00, 8'h00, 1'b1);
		tmp(CODE_HEAT_SINK, 8'h46, 8'h09, 8'h00, 8'h00, 1'b0);
		tmp(CODE_HEAT_SINK, 8'hff, 8'hff, 8'h00, 8'h00, 1'b1);
		tmp(CODE_INSIDE, 8'h00, 8'h00, 8'h3c, 8'h05, 1'b1);
		tmp(CODE_INSIDE, 8'h00, 8'h00, 8'h3c, 8'h04, 1'b0);
		tmp(CODE_OVER_TEMP, 8'h00, 8'h00, 8'h3c, 8'h05, 1'b1);
		tmp(CODE_OVER_TEMP, 8'h46, 8'h0a, 8'h00, 8'h00, 1'b1);
		tmp(CODE_OVER_TEMP, 8'h46, 8'h09, 8'h3c, 8'h04, 1'b0);
	endtask
	task t_reset();
		set0(CODE_ON);
		wt(1);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		wt(1);
		chk("reset", {controllerRelease, consumerLevel}, 10'h000);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		wt(1);
		chk("restart", consumerLevel[0], 1'b1);
	endtask
	task tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmpCount, fails);
		if (fails == 0 && cmpCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// The whole run needs well under a thousand cycles; the ceiling leaves margin.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_const();
		t_flags();
		t_pins();
		t_mfi();
		t_tech();
		t_mains();
		t_temp();
		t_reset();
		tally_and_finish();
	end
endmodule
bind dss_selector dss_selector_chk chk_u (.core_clk, .sys_rst, .sourceCode, .hwInputPin,
	.multifunctionInputMode, .remoteActive, .remoteBits, .driveConfig, .techStartCmd,
	.heatSinkTemp, .heatSinkOffset, .comparatorOne, .consumerLevel, .controllerRelease);

// file: sim/dss_terminals.sv
// Terminal model that drives the asynchronous input pins of the selector.
`timescale 1ns/1ps
module dss_terminals (
	input  wire logic       core_clk,
	input  wire logic [6:0] pinWant,
	output      logic [5:0] hwInputPin = 6'h00,
	output      logic       multifunctionInputPin = 1'b0
);
	// Contacts switch away from the clock edge, as a field signal would.
	always @(posedge core_clk) begin
		#2;
		{multifunctionInputPin, hwInputPin} = pinWant;
	end
endmodule
